// ==== rtl/twsp_top.v ====
// twsp_top.v: three-wire serial port with Avalon-MM register access,
// port direction and output latch for the shared port pins.
// assumes: one 50 MHz clock, async active-high reset, pins split into
// input, output and output enable; software keeps sck at or below 5 MHz.
//
// What this block does
// - enable low stops and async-resets serial logic
// - disable clears busy flag and shift register
// - mode bit: receive-only or transmit/receive; output low
// - receive-only: shift register read starts reception
// - order bit selects msb or lsb first
// - busy flag read-only, set during transfer
// - polarity and phase pick type 1..4
// - clock select divides by 2..128, 111 slave
// - reset: mode, clock 00h, direction ffh
// - direction 0 output driven, 1 input
// - stopped port: pins act as plain ports
// - transfer uses clock, output and input lines
// - transmit buffer write starts full-duplex transfer
// - after 8 bits: done flag, busy clears
// - output keeps last bit after transfer
`timescale 1ns/1ps
`default_nettype none
`include "twsp_defs.vh"

module twsp_top
(
  input  wire        clk_i,
  input  wire        reset_i,
  // avalon-mm slave, word addressed
  input  wire [15:0] avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // port pins: bit 0 clock, bit 1 data in, bit 2 data out
  input  wire [7:0]  port_pin_i,
  output wire [7:0]  port_pin_o,
  output wire [7:0]  port_pin_oe_o,
  // one-cycle pulse per finished 8-bit transfer
  output wire        transfer_done_irq_o
);

  //////////////////////////////////////////////////////////////////////
  // declarations
  //////////////////////////////////////////////////////////////////////
  reg  [7:0]  mode_ff;
  reg  [7:0]  clksel_ff;
  reg  [7:0]  portdir_ff;
  reg  [7:0]  portlat_ff;
  reg  [7:0]  txbuf_ff;
  reg         wait_ff;
  reg  [31:0] rdata_ff;
  reg  [7:0]  pin_o_ff;
  reg  [7:0]  pin_oe_ff;
  reg         busy_ff;
  reg  [7:0]  shift_ff;
  reg         so_ff;
  reg         sclk_ff;
  reg  [3:0]  edge_cnt_ff;
  reg  [5:0]  div_ff;
  reg         done_ff;
  reg         sck_prev_ff;

  reg  [7:0]  nxt_rdata;
  reg  [7:0]  nxt_pin_o;
  reg         nxt_first;

  wire [7:0]  pin_sync;
  wire        enable;
  wire        trmd;
  wire        lsb_first;
  wire        ckp;
  wire        dap;
  wire [2:0]  cks;
  wire        slave;
  wire        idle_lvl;
  wire        eng_rst;
  wire        req;
  wire        wr_fire;
  wire        rd_fire;
  wire        wr_lane0;
  wire [7:0]  wdata;
  wire        start_tx;
  wire        start_rx;
  wire        start;
  wire [5:0]  div_mask;
  wire        tick;
  wire        sck_in;
  wire        si_in;
  wire        sclk_edge;
  wire        launch_edge;
  wire        last_edge;
  wire        out_bit;
  wire        sck_out;

  //////////////////////////////////////////////////////////////////////
  // field decode
  //////////////////////////////////////////////////////////////////////
  assign enable    = mode_ff[`TWSP_MODE_EN_BIT];
  assign trmd      = mode_ff[`TWSP_MODE_TRMD_BIT];
  assign lsb_first = mode_ff[`TWSP_MODE_DIR_BIT];
  assign ckp       = clksel_ff[`TWSP_CLK_CKP_BIT];
  assign dap       = clksel_ff[`TWSP_CLK_DAP_BIT];
  assign cks       = clksel_ff[`TWSP_CLK_CKS_MSB:`TWSP_CLK_CKS_LSB];
  // code 111 hands the clock to the partner
  assign slave     = (cks == `TWSP_CKS_SLAVE);
  // type 1 after reset: clock idles high with both bits clear
  assign idle_lvl  = ~ckp;

  // serial logic held in reset while the port is disabled; enable is a
  // flop output, so the reset term carries no decode glitches
  assign eng_rst   = reset_i | ~enable;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  //////////////////////////////////////////////////////////////////////
  twsp_sync
  #(
    .W (8)
  )
  u_pin_sync
  (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i (port_pin_i),
    .sync_o  (pin_sync)
  );

  assign sck_in = pin_sync[`TWSP_PIN_SCK];
  assign si_in  = pin_sync[`TWSP_PIN_SI];

  //////////////////////////////////////////////////////////////////////
  // avalon handshake: one wait cycle, then waitrequest low for one cycle
  //////////////////////////////////////////////////////////////////////
  assign req      = avs_read_i | avs_write_i;
  assign wr_fire  = avs_write_i & ~wait_ff;
  assign rd_fire  = avs_read_i & ~wait_ff;
  assign wr_lane0 = wr_fire & avs_byteenable_i[0];
  assign wdata    = avs_writedata_i[7:0];

  // wait drops the cycle after a request is seen, rises after acceptance
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      wait_ff <= 1'b1;
    else
      wait_ff <= ~(req & wait_ff);
  end

  //////////////////////////////////////////////////////////////////////
  // transfer start decode
  //////////////////////////////////////////////////////////////////////
  // a start while busy is dropped; software must not touch data then
  assign start_tx = wr_lane0 & (avs_address_i == `TWSP_IDX_TXBUF) &
                    enable & trmd & ~busy_ff;
  assign start_rx = rd_fire & (avs_address_i == `TWSP_IDX_SHIFT) &
                    enable & ~trmd & ~busy_ff;
  assign start    = start_tx | start_rx;

  //////////////////////////////////////////////////////////////////////
  // software registers
  //////////////////////////////////////////////////////////////////////
  // bits 5 and 3..1 of mode are not stored and read zero
  // clock select is writable at any time; keeping it still while
  // enabled is left to software
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      mode_ff    <= `TWSP_RST_MODE;
      clksel_ff  <= `TWSP_RST_CLKSEL;
      portdir_ff <= `TWSP_RST_PORTDIR;
      portlat_ff <= `TWSP_RST_PORTLAT;
      txbuf_ff   <= `TWSP_RST_TXBUF;
    end
    else if (wr_lane0)
    begin
      case (avs_address_i)
        `TWSP_IDX_MODE:
        begin
          mode_ff[`TWSP_MODE_EN_BIT]   <= wdata[`TWSP_MODE_EN_BIT];
          mode_ff[`TWSP_MODE_TRMD_BIT] <= wdata[`TWSP_MODE_TRMD_BIT];
          mode_ff[`TWSP_MODE_DIR_BIT]  <= wdata[`TWSP_MODE_DIR_BIT];
        end
        `TWSP_IDX_CLKSEL:
        begin
          clksel_ff <= {3'h0, wdata[4:0]};
        end
        `TWSP_IDX_PORTDIR:
        begin
          portdir_ff <= wdata;
        end
        `TWSP_IDX_PORTLAT:
        begin
          portlat_ff <= wdata;
        end
        `TWSP_IDX_TXBUF:
        begin
          txbuf_ff <= wdata;
        end
        default:
        begin
          txbuf_ff <= txbuf_ff;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read mux, captured in the wait cycle so data stand with the answer
  //////////////////////////////////////////////////////////////////////
  always @*
  begin
    nxt_rdata = 8'h00;
    case (avs_address_i)
      `TWSP_IDX_MODE:
        // busy is status only; writes to bit 0 never reach it
        nxt_rdata = {mode_ff[7:1], busy_ff};
      `TWSP_IDX_CLKSEL:
        nxt_rdata = clksel_ff;
      `TWSP_IDX_PORTDIR:
        nxt_rdata = portdir_ff;
      `TWSP_IDX_PORTLAT:
        nxt_rdata = portlat_ff;
      `TWSP_IDX_TXBUF:
        nxt_rdata = txbuf_ff;
      `TWSP_IDX_SHIFT:
        nxt_rdata = shift_ff;
      `TWSP_IDX_PINS:
        nxt_rdata = pin_sync;
      default:
        nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_ff <= 32'h0000_0000;
    else if (avs_read_i & wait_ff)
      rdata_ff <= {24'h00_0000, nxt_rdata};
  end

  //////////////////////////////////////////////////////////////////////
  // clock divider: half period of 2^cks system clocks
  //////////////////////////////////////////////////////////////////////
  assign div_mask = (6'h01 << cks) - 6'h01;
  assign tick     = ((div_ff & div_mask) == div_mask);

  // slave edges come from any change of the synchronised clock pin;
  // the partner must not clock before the start (stop state)
  assign sclk_edge   = busy_ff & (slave ? (sck_in != sck_prev_ff) : tick);
  // phase 0 launches on even edges, phase 1 on odd edges
  assign launch_edge = dap ? edge_cnt_ff[0] : ~edge_cnt_ff[0];
  assign last_edge   = (edge_cnt_ff == `TWSP_LAST_EDGE);
  // next bit out comes from the end picked by the order bit
  assign out_bit     = lsb_first ? shift_ff[0] : shift_ff[7];

  // first bit for phase 1 is launched straight from the written data
  always @*
  begin
    nxt_first = lsb_first ? wdata[0] : wdata[7];
  end

  //////////////////////////////////////////////////////////////////////
  // shift engine, asynchronously cleared while disabled
  //////////////////////////////////////////////////////////////////////
  always @(posedge clk_i or posedge eng_rst)
  begin
    if (eng_rst)
    begin
      busy_ff     <= 1'b0;
      shift_ff    <= `TWSP_RST_SHIFT;
      so_ff       <= 1'b0;
      sclk_ff     <= 1'b1;
      edge_cnt_ff <= 4'h0;
      div_ff      <= 6'h00;
      done_ff     <= 1'b0;
      sck_prev_ff <= 1'b0;
    end
    else
    begin
      done_ff     <= 1'b0;
      sck_prev_ff <= sck_in;
      div_ff      <= busy_ff ? (div_ff + 6'h01) : 6'h00;
      if (start)
      begin
        busy_ff     <= 1'b1;
        edge_cnt_ff <= 4'h0;
        div_ff      <= 6'h00;
        sclk_ff     <= idle_lvl;
        if (start_tx)
          shift_ff <= wdata;
        if (start_tx & dap)
          so_ff <= nxt_first;
      end
      else if (sclk_edge)
      begin
        edge_cnt_ff <= edge_cnt_ff + 4'h1;
        sclk_ff     <= ~sclk_ff;
        // no launch on the closing edge, so the last bit stays
        if (launch_edge & ~last_edge & trmd)
          so_ff <= out_bit;
        // sample on the edge opposite the launch
        if (~launch_edge)
        begin
          if (lsb_first)
            shift_ff <= {si_in, shift_ff[7:1]};
          else
            shift_ff <= {shift_ff[6:0], si_in};
        end
        // sixteen edges close one 8-bit transfer
        if (last_edge)
        begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
      // receive-only keeps the data output low
      if (~trmd)
        so_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pin drive: registered so every output comes from a flop
  //////////////////////////////////////////////////////////////////////
  // master clock is gated by the latch, so latch must hold 1
  assign sck_out = busy_ff ? sclk_ff : idle_lvl;

  always @*
  begin
    nxt_pin_o = portlat_ff;
    // a stopped port leaves every pin to its latch
    if (enable)
    begin
      if (~slave)
        nxt_pin_o[`TWSP_PIN_SCK] = portlat_ff[`TWSP_PIN_SCK] & sck_out;
      // data out merges with the latch, which must hold 0
      nxt_pin_o[`TWSP_PIN_SO] = portlat_ff[`TWSP_PIN_SO] | (trmd & so_ff);
    end
  end

  // direction 0 drives the pin, 1 leaves it as input
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pin_o_ff  <= 8'h00;
      pin_oe_ff <= 8'h00;
    end
    else
    begin
      pin_o_ff  <= nxt_pin_o;
      pin_oe_ff <= ~portdir_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  //////////////////////////////////////////////////////////////////////
  assign avs_readdata_o      = rdata_ff;
  assign avs_waitrequest_o   = wait_ff;
  assign port_pin_o          = pin_o_ff;
  assign port_pin_oe_o       = pin_oe_ff;
  // done pulse dies with a disable as part of the engine reset
  assign transfer_done_irq_o = done_ff;

endmodule // twsp_top

`default_nettype wire

// ==== pkg/twsp_defs.vh ====
// twsp_defs.vh: register indices, field positions and reset values
// for the three-wire serial port block.
// assumes: included by bare name; definitions only.
`ifndef TWSP_DEFS_VH
`define TWSP_DEFS_VH

// register indices (word index; byte address is four times the index)
`define TWSP_IDX_MODE      16'hff80
`define TWSP_IDX_CLKSEL    16'hff81
`define TWSP_IDX_PORTDIR   16'hff82
`define TWSP_IDX_PORTLAT   16'hff83
`define TWSP_IDX_TXBUF     16'hff84
`define TWSP_IDX_SHIFT     16'hff85
`define TWSP_IDX_PINS      16'hff86

// serial_mode_control fields
`define TWSP_MODE_EN_BIT   7
`define TWSP_MODE_TRMD_BIT 6
`define TWSP_MODE_DIR_BIT  4
`define TWSP_MODE_BUSY_BIT 0

// serial_clock_phase_select fields
`define TWSP_CLK_CKP_BIT   4
`define TWSP_CLK_DAP_BIT   3
`define TWSP_CLK_CKS_MSB   2
`define TWSP_CLK_CKS_LSB   0
`define TWSP_CKS_SLAVE     3'h7

// port bit assignment
`define TWSP_PIN_SCK       0
`define TWSP_PIN_SI        1
`define TWSP_PIN_SO        2

// reset values
`define TWSP_RST_MODE      8'h00
`define TWSP_RST_CLKSEL    8'h00
`define TWSP_RST_PORTDIR   8'hff
`define TWSP_RST_PORTLAT   8'h00
`define TWSP_RST_TXBUF     8'h00
`define TWSP_RST_SHIFT     8'h00

// last clock edge of an 8-bit transfer (16 edges, counted from 0)
`define TWSP_LAST_EDGE     4'hf

`endif

// ==== rtl/twsp_sync.v ====
// twsp_sync.v: two-flop synchroniser for pin inputs.
// assumes: inputs are asynchronous to clk_i; first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none

module twsp_sync
#(
  parameter W = 8
)
(
  input  wire         clk_i,
  input  wire         reset_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // plain double flop; no logic between stages
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule // twsp_sync

`default_nettype wire

// ==== test/twsp_assertions.sv ====
// twsp_assertions.sv: port checker for twsp_top.
// assumes: bound into every twsp_top; one clock domain.
`timescale 1ns/1ps
`default_nettype none

module twsp_chk
(
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [15:0] avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [7:0]  port_pin_o,
  input wire logic [7:0]  port_pin_oe_o,
  input wire logic        transfer_done_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  ////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then a single ready cycle
  chk_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("request not answered in one cycle");
  chk_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  chk_wait_idle: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
    else $error("waitrequest low without a request");
  chk_rdata_upper: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  // unmapped reads return zero; writes leave the read data alone
  chk_rd_unmapped: assert property (avs_read_i && avs_waitrequest_o
    && avs_address_i > 16'hff86 |=> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_wr_keeps_rdata: assert property (avs_write_i && !avs_waitrequest_o
    |=> $stable(avs_readdata_o)) else $error("write disturbed read data");

  ////////////////////////////////////////////////////////////////////
  // sixteen clock edges of at least one cycle lie between two ends
  chk_done_spacing: assert property (transfer_done_irq_o |=> !transfer_done_irq_o [*8])
    else $error("transfer done pulses too close");
  chk_pins_reset: assert property ($past(reset_i) |-> port_pin_oe_o == 8'h00
    && port_pin_o == 8'h00) else $error("pins not released after reset");

  cov_done: cover property (transfer_done_irq_o);
  cov_read: cover property (avs_read_i && !avs_waitrequest_o);
  cov_write: cover property (avs_write_i && !avs_waitrequest_o);
endmodule // twsp_chk

bind twsp_top twsp_chk chk_u
(
  .clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o),
  .transfer_done_irq_o(transfer_done_irq_o)
);

`default_nettype wire

// ==== test/twsp_peer.sv ====
// twsp_peer.sv: clocked serial peripheral on the far side of the pins.
// assumes: clock idles high (types 1 and 2), msb first on its side;
// dap_i tells it which edge launches.
`timescale 1ns/1ps
`default_nettype none

module twsp_peer
(
  input  wire logic       sck_i,
  input  wire logic       so_i,
  input  wire logic       arm_i,
  input  wire logic       dap_i,
  input  wire logic [7:0] tx_i,
  output logic            si_o,
  output logic [7:0]      rx_o
);
  int n = 0;

  initial si_o = 1'b0;
  initial rx_o = 8'h00;

  // phase 0 launches on the falling edge, phase 1 on the rising edge
  // with the first bit already out at arm; the other edge samples.
  // after the last bit the line is let go and flips, so stale data
  // never looks valid
  always @(posedge sck_i or negedge sck_i or posedge arm_i)
    if (arm_i)
    begin
      n <= dap_i;
      si_o <= tx_i[7];
    end
    else if (sck_i == dap_i)
    begin
      if (n < 8)
      begin
        si_o <= tx_i[7-n];
        n <= n + 1;
      end
    end
    else
    begin
      rx_o <= {rx_o[6:0], so_i};
      if (n == 8)
        si_o <= ~si_o;
    end
endmodule // twsp_peer

`default_nettype wire

// ==== test/tb_top.sv ====
// tb_top.sv: self-checking bench for twsp_top against a serial peer.
// assumes: twsp_defs.vh on the include path; 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "twsp_defs.vh"

module tb_top;
  localparam logic [15:0] a_md = `TWSP_IDX_MODE;
  localparam logic [15:0] a_cs = `TWSP_IDX_CLKSEL;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [15:0] adr = 16'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  wire  [31:0] rdat;
  wire         wreq;
  wire  [7:0]  pin_o;
  wire  [7:0]  pin_oe;
  wire  [7:0]  pin_i;
  wire         done;
  wire         si;
  wire  [7:0]  prx;
  logic [7:0]  ptx = 8'h0;
  logic        arm = 1'b0;
  logic        pdap = 1'b0;
  logic [7:0]  q;
  int          err_count = 0;
  int          compares = 0;
  int          cyc = 0;

  // the bench never clocks the pin in slave mode, so no slave start
  // can meet a stop state
  // undriven pins float high; bit 1 carries the peer's data
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & {6'h3f, si, 1'b1});

  twsp_top dut_u
  (
    .clk_i(clk_i), .reset_i(reset_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'h1), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .port_pin_i(pin_i), .port_pin_o(pin_o),
    .port_pin_oe_o(pin_oe), .transfer_done_irq_o(done)
  );

  twsp_peer peer_u
  (
    .sck_i(pin_i[0]), .so_i(pin_i[2]), .arm_i(arm), .dap_i(pdap), .tx_i(ptx),
    .si_o(si), .rx_o(prx)
  );

  initial forever #10 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("errors=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      give_verdict;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  // only the cycle timeout ends a wait that never comes
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= ~w;
    do
    begin
      @(posedge clk_i);
    end
    while (wreq !== 1'b0);
    q = rdat[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h0);
    chk({24'h0, q}, {24'h0, e});
  endtask

  task automatic wdone;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, done}, 32'h1);
  endtask

  function automatic logic [7:0] rev(input logic [7:0] v);
    return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
  endfunction

  // clock select is only rewritten while disabled divide by 16
  // keeps the serial clock at 3.125 MHz ph is {polarity, phase}
  task automatic setup(input logic [1:0] ph, input logic [7:0] md);
    bus(1'b1, a_md, 8'h00);
    bus(1'b1, a_cs, {3'h0, ph, 3'h3});
    bus(1'b1, a_md, md);
    // pin flops follow the registers one edge later
    @(posedge clk_i);
    chk({31'h0, pin_o[0]}, {31'h0, ~ph[1]});
    ptx <= ~md;
    pdap <= ph[0];
    arm <= 1'b1;
    @(posedge clk_i);
    arm <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(a_md, 8'h00);
    rdc(a_cs, 8'h00);
    rdc(`TWSP_IDX_PORTDIR, 8'hff);
    rdc(16'hff90, 8'h00);
    chk({24'h0, pin_oe}, 32'h0);
    bus(1'b1, a_md, 8'hdf);
    rdc(a_md, 8'hd0);
    bus(1'b1, a_md, 8'h00);
    bus(1'b1, `TWSP_IDX_PORTLAT, 8'h01);
    bus(1'b1, `TWSP_IDX_PORTDIR, 8'hfa);
    @(posedge clk_i);
    chk({24'h0, pin_oe}, 32'h05);
    chk({24'h0, pin_o}, 32'h01);
  endtask

  task automatic t_xfer(input logic dap, input logic dir, input logic [7:0] d);
    setup({1'b0, dap}, {3'h6, dir, 4'h0});
    bus(1'b1, `TWSP_IDX_TXBUF, d);
    rdc(a_md, {3'h6, dir, 4'h1});
    wdone;
    rdc(a_md, {3'h6, dir, 4'h0});
    chk({24'h0, prx}, {24'h0, dir ? rev(d) : d});
    rdc(`TWSP_IDX_SHIFT, dir ? rev(ptx) : ptx);
    chk({31'h0, pin_o[2]}, {31'h0, dir ? d[7] : d[0]});
  endtask

  task automatic t_rxonly;
    setup(2'h0, 8'h80);
    rdc(`TWSP_IDX_SHIFT, 8'h00);
    rdc(a_md, 8'h81);
    chk({31'h0, pin_o[2]}, 32'h0);
    wdone;
    rdc(`TWSP_IDX_SHIFT, 8'h7f);
  endtask

  // a disable while busy clears the busy flag and the shift register
  task automatic t_disable;
    setup(2'h0, 8'hc0);
    bus(1'b1, `TWSP_IDX_TXBUF, 8'h5a);
    rdc(a_md, 8'hc1);
    bus(1'b1, a_md, 8'h40);
    rdc(a_md, 8'h40);
    rdc(`TWSP_IDX_SHIFT, 8'h00);
    setup(2'h2, 8'hc0);
    bus(1'b1, a_md, 8'h00);
  endtask

  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_xfer(1'b0, 1'b0, 8'hc5);
    t_xfer(1'b0, 1'b1, 8'h4c);
    t_xfer(1'b1, 1'b0, 8'ha3);
    t_rxonly;
    t_disable;
    give_verdict;
  end
endmodule // tb_top

`default_nettype wire
